// *** rtl/cdmf_pkg.sv ***
// shared types and constants for the data-move and flag core
package cdmf_pkg;
  localparam logic [1:0]  T_ADDR = 2'h0;            // first state: address and strobes out
  localparam logic [1:0]  T_DATA = 2'h2;            // third state: data taken, strobes drop
  localparam logic [1:0]  T_EXEC = 2'h3;            // fourth state of the fetch cycle
  localparam logic [2:0]  M_FETCH = 3'h0;
  localparam logic [2:0]  REG_M   = 3'h6;           // memory operand code in selector fields
  localparam logic [2:0]  REG_A   = 3'h7;           // accumulator
  localparam logic [2:0]  REG_H   = 3'h4;
  localparam logic [2:0]  REG_L   = 3'h5;
  localparam logic [1:0]  PAIR_HL = 2'h2;
  localparam logic [1:0]  PAIR_SP = 2'h3;
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [15:0] RESET_SP = 16'h0000;
  localparam logic [7:0]  OP_HALT  = 8'h76;
  localparam logic [7:0]  OP_LDA   = 8'h3A;
  localparam logic [7:0]  OP_STA   = 8'h32;
  localparam logic [7:0]  OP_LOAD_POINTER_PAIR_DIRECT  = 8'h2A;
  localparam logic [7:0]  OP_STORE_POINTER_PAIR_DIRECT  = 8'h22;
  localparam logic [7:0]  OP_JMP   = 8'hC3;
  localparam logic [7:0]  OP_PCHL  = 8'hE9;
  localparam logic [7:0]  MASK_PAIR = 8'hCF;        // clears the pair field
  localparam logic [7:0]  OP_LXI   = 8'h01;
  localparam logic [7:0]  OP_LOAD_ACC_VIA_PAIR  = 8'h0A;
  localparam logic [7:0]  MASK_DST = 8'hC7;         // clears the dest/restart field
  localparam logic [7:0]  OP_MVI   = 8'h06;
  localparam logic [7:0]  OP_RST   = 8'hC7;
  localparam logic [1:0]  GRP_MOV  = 2'h1;

  typedef enum logic [3:0] {
    CLS_NOP  = 4'b0000, CLS_MOVRR = 4'b0001, CLS_MOVRM = 4'b0010, CLS_MOVMR = 4'b0011,
    CLS_MVIR = 4'b0100, CLS_MVIM  = 4'b0101, CLS_LXI   = 4'b0110, CLS_LDA   = 4'b0111,
    CLS_STA  = 4'b1000, CLS_LOAD_POINTER_PAIR_DIRECT  = 4'b1001, CLS_STORE_POINTER_PAIR_DIRECT  = 4'b1010, CLS_LOAD_ACC_VIA_PAIR  = 4'b1011,
    CLS_JMP  = 4'b1100, CLS_PCHL  = 4'b1101, CLS_RST   = 4'b1110
  } cdmf_class_t;

  typedef struct packed {
    logic sign;
    logic zero;
    logic halfCarry;
    logic parity;
    logic carry;
  } cdmf_flags_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } cdmf_mem_t;

  typedef struct packed {
    logic       we;        // update zero, sign, parity, half carry
    logic       carryWe;   // also update carry
    logic       sub;       // subtract/compare instead of add
    logic [7:0] opA;
    logic [7:0] opB;
    logic       cin;       // carry or borrow in
  } cdmf_flag_req_t;
endpackage

// *** rtl/cdmf_core.sv ***
// data transfer, addressing and condition flag core of an 8-bit processor
// Functional notes
// - memory is bytes at unique 16-bit addresses, 64K locations, RAM or ROM
// - bit 0 is least significant, bit 7 most significant
// - instructions are 1-3 consecutive bytes, addressed by their opcode byte
// - multi-byte data sits low byte at the lowest address
// - direct address: byte two is low half, byte three is high half
// - indirect address: first register of pair high, second low
// - immediate operand is one byte or two, low byte first
// - fetch rises sequentially; jumps take direct or pair targets
// - restart jumps to eight times its 3-bit field
// - five flags kept; set writes 1, reset writes 0
// - zero set on zero result, sign set on result bit 7
// - parity set when the result has an even count of ones
// - carry set on carry out of addition or borrow of subtraction
// - half carry set on carry from bit 3 into bit 4
// - data transfer instructions never touch any flag
// - register copy takes one cycle of four states
// - register/memory copy either way takes two cycles, seven states
// - immediate byte load: 7 states to register, 10 to memory
// - pair immediate load puts byte three high, byte two low, 10 states
// - direct accumulator load and store take 4 cycles, 13 states
// - direct pair load/store: low at address, high at next, 16 states
// - indirect accumulator load accepts only the first two pairs
// - register fields: A is 111, six registers 000 to 101
// - pair fields: three pairs 00 to 10, stack pointer 11
`timescale 1ns/1ns
module cdmf_core
  import cdmf_pkg::*;
(
  input  wire logic           clk,        // 25 MHz clock
  input  wire logic           rst_n,      // synchronous reset, active low
  input  wire logic [7:0]     memRdata,   // byte read from memory
  input  wire cdmf_flag_req_t flagReq,    // flag update from arithmetic and logic
  output cdmf_mem_t           mem,        // memory address, strobes, write data
  output cdmf_flags_t         flags,      // condition flags
  output logic [15:0]         pc,         // program counter
  output logic [7:0]          acc,        // accumulator
  output logic                instrDone   // pulse: instruction finished
);

  // states within one machine cycle; only the opcode fetch uses the fourth
  typedef enum logic [1:0] {
    TS_ADDR = 2'b00,
    TS_WAIT = 2'b01,
    TS_DATA = 2'b10,
    TS_EXEC = 2'b11
  } cdmf_tstate_t;

  typedef struct packed {
    logic [15:0]     pc;
    logic [15:0]     sp;
    logic [7:0][7:0] regs;
    cdmf_flags_t     flags;
    logic [7:0]      ir;
    logic [7:0]      b2;
    logic [7:0]      b3;
    logic [2:0]      mcyc;
    cdmf_tstate_t    tst;
    cdmf_mem_t       mem;
    logic            done;
  } cdmf_state_t;

  cdmf_state_t s_q;
  cdmf_state_t s_d;

  // opcode classes; only pairs 00 and 01 form the indirect load
  function automatic cdmf_class_t decode(input logic [7:0] op);
    cdmf_class_t c;
    c = CLS_NOP;
    if (op[7:6] == GRP_MOV) begin
      // halt code is left as a no-op: machine control is not in this core
      if (op == OP_HALT) c = CLS_NOP;
      else if (op[2:0] == REG_M) c = CLS_MOVRM;
      else if (op[5:3] == REG_M) c = CLS_MOVMR;
      else c = CLS_MOVRR;
    end
    else if ((op & MASK_DST) == OP_MVI) c = (op[5:3] == REG_M) ? CLS_MVIM : CLS_MVIR;
    else if ((op & MASK_PAIR) == OP_LXI) c = CLS_LXI;
    else if ((op & MASK_PAIR) == OP_LOAD_ACC_VIA_PAIR && !op[5]) c = CLS_LOAD_ACC_VIA_PAIR;
    else if (op == OP_LDA) c = CLS_LDA;
    else if (op == OP_STA) c = CLS_STA;
    else if (op == OP_LOAD_POINTER_PAIR_DIRECT) c = CLS_LOAD_POINTER_PAIR_DIRECT;
    else if (op == OP_STORE_POINTER_PAIR_DIRECT) c = CLS_STORE_POINTER_PAIR_DIRECT;
    else if (op == OP_JMP) c = CLS_JMP;
    else if (op == OP_PCHL) c = CLS_PCHL;
    else if ((op & MASK_DST) == OP_RST) c = CLS_RST;
    return c;
  endfunction

  // immediate bytes that follow the opcode
  function automatic logic [2:0] immCount(input cdmf_class_t c);
    case (c)
      CLS_MVIR, CLS_MVIM: immCount = 3'h1;
      CLS_LXI, CLS_LDA, CLS_STA, CLS_LOAD_POINTER_PAIR_DIRECT, CLS_STORE_POINTER_PAIR_DIRECT, CLS_JMP: immCount = 3'h2;
      default: immCount = 3'h0;
    endcase
  endfunction

  // data bytes moved after the immediate bytes
  function automatic logic [2:0] memCount(input cdmf_class_t c);
    case (c)
      CLS_MOVRM, CLS_MOVMR, CLS_MVIM, CLS_LDA, CLS_STA, CLS_LOAD_ACC_VIA_PAIR: memCount = 3'h1;
      CLS_LOAD_POINTER_PAIR_DIRECT, CLS_STORE_POINTER_PAIR_DIRECT: memCount = 3'h2;
      default: memCount = 3'h0;
    endcase
  endfunction

  function automatic logic [15:0] pairVal(input logic [7:0][7:0] r, input logic [15:0] sp,
                                          input logic [1:0] p);
    if (p == PAIR_SP) pairVal = sp;
    else pairVal = {r[{p, 1'b0}], r[{p, 1'b1}]};
  endfunction

  // even count of ones sets parity
  function automatic logic evenParity(input logic [7:0] v);
    evenParity = ~^v;
  endfunction

  // next sequential byte address, wraps in 16 bits
  function automatic logic [15:0] nextAddr(input logic [15:0] a);
    nextAddr = a + 16'h0001;
  endfunction

  // register read by selector; code 110 is memory and never reaches here
  function automatic logic [7:0] regRead(input logic [7:0][7:0] r, input logic [2:0] sel);
    regRead = r[sel];
  endfunction

  cdmf_class_t cls;
  logic [2:0]  nImm;
  logic [2:0]  nLast;
  logic [2:0]  memIdx;
  logic        pcFetch;
  logic [15:0] dataAddr;
  logic [8:0]  wide;
  logic [4:0]  nib;
  logic [7:0]  opB;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    cls      = decode(s_q.ir);
    nImm     = immCount(cls);
    nLast    = nImm + memCount(cls);
    memIdx   = s_q.mcyc - nImm;
    pcFetch  = (s_q.mcyc != M_FETCH) && (s_q.mcyc <= nImm);
    // direct address, second byte wraps in 16 bits
    dataAddr = {s_q.b3, s_q.b2} + {13'h0000, memIdx} - 16'h0001;
    case (cls)
      CLS_MOVRM, CLS_MOVMR, CLS_MVIM: dataAddr = pairVal(s_q.regs, s_q.sp, PAIR_HL);
      CLS_LOAD_ACC_VIA_PAIR: dataAddr = pairVal(s_q.regs, s_q.sp, s_q.ir[5:4]);
      default: ;
    endcase

    // flag update requested by the arithmetic side
    opB  = flagReq.sub ? ~flagReq.opB : flagReq.opB;
    wide = {1'b0, flagReq.opA} + {1'b0, opB} + {8'h00, flagReq.cin ^ flagReq.sub};
    nib  = {1'b0, flagReq.opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, flagReq.cin ^ flagReq.sub};
    // only the flag port writes flags; no transfer path does
    if (flagReq.we) begin
      s_d.flags.zero      = (wide[7:0] == 8'h00);
      s_d.flags.sign      = wide[7];
      s_d.flags.parity    = evenParity(wide[7:0]);
      s_d.flags.halfCarry = nib[4];
      if (flagReq.carryWe) s_d.flags.carry = wide[8] ^ flagReq.sub;
    end

    // no wait states: memory must answer by the end of the third state
    case (s_q.tst)
    TS_ADDR: begin
      // opcode and immediates come from ascending pc
      if (s_q.mcyc == M_FETCH || pcFetch) begin
        s_d.mem.addr = s_q.pc;
        s_d.mem.rd   = 1'b1;
      end
      else begin
        s_d.mem.addr = dataAddr;
        case (cls)
          CLS_MOVMR: begin
            s_d.mem.wr    = 1'b1;
            s_d.mem.wdata = regRead(s_q.regs, s_q.ir[2:0]);
          end
          CLS_MVIM: begin
            s_d.mem.wr    = 1'b1;
            s_d.mem.wdata = s_q.b2;
          end
          CLS_STA: begin
            s_d.mem.wr    = 1'b1;
            s_d.mem.wdata = s_q.regs[REG_A];
          end
          // low register first, high at the next address
          CLS_STORE_POINTER_PAIR_DIRECT: begin
            s_d.mem.wr    = 1'b1;
            s_d.mem.wdata = (memIdx == 3'h1) ? s_q.regs[REG_L] : s_q.regs[REG_H];
          end
          default: s_d.mem.rd = 1'b1;
        endcase
      end
      s_d.tst = TS_WAIT;
    end
    TS_DATA: begin
      s_d.mem.rd = 1'b0;
      s_d.mem.wr = 1'b0;
      if (s_q.mcyc == M_FETCH) begin
        s_d.ir  = memRdata;
        s_d.pc  = nextAddr(s_q.pc);
        s_d.tst = TS_EXEC;
      end
      else begin
        if (pcFetch) begin
          s_d.pc = nextAddr(s_q.pc);
          if (s_q.mcyc == 3'h1) s_d.b2 = memRdata;
          else s_d.b3 = memRdata;
        end
        else begin
          case (cls)
            // memory byte into the selected register
            CLS_MOVRM: s_d.regs[s_q.ir[5:3]] = memRdata;
            CLS_LDA, CLS_LOAD_ACC_VIA_PAIR: s_d.regs[REG_A] = memRdata;
            // low byte to L, next byte to H
            CLS_LOAD_POINTER_PAIR_DIRECT: begin
              if (memIdx == 3'h1) s_d.regs[REG_L] = memRdata;
              else s_d.regs[REG_H] = memRdata;
            end
            default: ;
          endcase
        end
        if (s_q.mcyc == nLast) begin
          case (cls)
            CLS_MVIR: s_d.regs[s_q.ir[5:3]] = memRdata;
            // byte three high, byte two low
            CLS_LXI: begin
              if (s_q.ir[5:4] == PAIR_SP) s_d.sp = {memRdata, s_q.b2};
              else begin
                s_d.regs[{s_q.ir[5:4], 1'b0}] = memRdata;
                s_d.regs[{s_q.ir[5:4], 1'b1}] = s_q.b2;
              end
            end
            // direct branch target from bytes two and three
            CLS_JMP: s_d.pc = {memRdata, s_q.b2};
            default: ;
          endcase
          s_d.mcyc = M_FETCH;
          s_d.tst  = TS_ADDR;
          s_d.done = 1'b1;
        end
        else begin
          s_d.mcyc = s_q.mcyc + 3'h1;
          s_d.tst  = TS_ADDR;
        end
      end
    end
    TS_EXEC: begin
      // register copy finishes in the fourth state
      case (cls)
        CLS_MOVRR: s_d.regs[s_q.ir[5:3]] = regRead(s_q.regs, s_q.ir[2:0]);
        CLS_PCHL: s_d.pc = pairVal(s_q.regs, s_q.sp, PAIR_HL);
        // restart target is the field times eight; no stack push here
        CLS_RST: s_d.pc = {10'h000, s_q.ir[5:3], 3'h0};
        default: ;
      endcase
      s_d.tst = TS_ADDR;
      if (nLast == 3'h0) begin
        s_d.done = 1'b1;
        s_d.mcyc = M_FETCH;
      end
      else s_d.mcyc = 3'h1;
    end
    TS_WAIT: s_d.tst = TS_DATA;
    default: s_d.tst = TS_ADDR;
    endcase
  end

  // reset restarts execution at address zero with every flag clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q       <= '0;
      s_q.pc    <= RESET_PC;
      s_q.sp    <= RESET_SP;
      s_q.tst   <= TS_ADDR;
      s_q.mcyc  <= M_FETCH;
    end
    else begin
      s_q <= s_d;
    end
  end

  assign mem       = s_q.mem;
  assign flags     = s_q.flags;
  assign pc        = s_q.pc;
  assign acc       = s_q.regs[REG_A];
  assign instrDone = s_q.done;

endmodule

// *** dv/cdmf_core_checker.sv ***
// bus and flag assertions for the data-move and flag core
`timescale 1ns/1ns
module cdmf_core_checker
  import cdmf_pkg::*;
(
  input wire logic           clk,       // core clock
  input wire logic           rst_n,     // synchronous reset, active low
  input wire cdmf_flag_req_t flagReq,   // flag update request
  input wire cdmf_mem_t      mem,       // memory bus
  input wire cdmf_flags_t    flags,     // condition flags
  input wire logic           instrDone  // end of instruction
);
  logic [8:0] sum9;
  logic [4:0] low5;
  // borrow shows in bit 8 of the widened difference
  assign sum9 = flagReq.sub ? {1'b0, flagReq.opA} - {1'b0, flagReq.opB} - 9'(flagReq.cin)
                            : {1'b0, flagReq.opA} + {1'b0, flagReq.opB} + 9'(flagReq.cin);
  assign low5 = flagReq.sub ? {1'b0, flagReq.opA[3:0]} + {1'b0, ~flagReq.opB[3:0]} + 5'(!flagReq.cin)
                            : {1'b0, flagReq.opA[3:0]} + {1'b0, flagReq.opB[3:0]} + 5'(flagReq.cin);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  rd_pulse_a: assert property ($rose(mem.rd) |=> mem.rd ##1 !mem.rd)
    else $error("read strobe width wrong");
  wr_pulse_a: assert property ($rose(mem.wr) |=> mem.wr ##1 !mem.wr)
    else $error("write strobe width wrong");
  strobe_excl_a: assert property (!(mem.rd && mem.wr))
    else $error("read and write together");
  addr_hold_a: assert property ((mem.rd || mem.wr) && $past(mem.rd || mem.wr) |-> $stable(mem.addr))
    else $error("address moved during strobe");
  wdata_hold_a: assert property (mem.wr && $past(mem.wr) |-> $stable(mem.wdata))
    else $error("write data moved during strobe");
  done_pulse_a: assert property (instrDone |=> !instrDone [*3])
    else $error("instructions closer than four states");
  zero_sign_a: assert property (flagReq.we |=> flags.zero == ($past(sum9[7:0]) == 8'h00) && flags.sign == $past(sum9[7]))
    else $error("zero or sign flag wrong");
  parity_flag_a: assert property (flagReq.we |=> flags.parity == ~^$past(sum9[7:0]))
    else $error("parity flag wrong");
  carry_flag_a: assert property (flagReq.we && flagReq.carryWe |=> flags.carry == $past(sum9[8]))
    else $error("carry flag wrong");
  half_carry_a: assert property (flagReq.we |=> flags.halfCarry == $past(low5[4]))
    else $error("half carry flag wrong");
  carry_hold_a: assert property (flagReq.we && !flagReq.carryWe |=> $stable(flags.carry))
    else $error("carry changed without request");
  flags_stand_a: assert property (!flagReq.we |=> $stable(flags))
    else $error("flags changed without request");
endmodule
bind cdmf_core cdmf_core_checker cdmf_core_checker_inst (.clk(clk), .rst_n(rst_n), .flagReq(flagReq), .mem(mem),
  .flags(flags), .instrDone(instrDone));

// *** dv/cdmf_mem_model.sv ***
// byte-wide memory answering the core's read and write cycles
`timescale 1ns/1ns
module cdmf_mem_model
  import cdmf_pkg::*;
(
  input  wire logic      clk,      // core clock
  input  wire cdmf_mem_t memBus,   // address, strobes, write data
  output logic [7:0]     memRdata  // read byte
);
  logic [7:0] memQ [0:65535];
  logic [7:0] lastQ = 8'h00;
  initial for (int i = 0; i < 65536; i++) memQ[i] = 8'h76;
  always @(posedge clk) begin
    if (memBus.wr) memQ[memBus.addr] <= memBus.wdata;
    if (memBus.rd) lastQ <= memRdata;
  end
  // released bus shows the inverse, never a stale byte
  assign memRdata = memBus.rd ? memQ[memBus.addr] : ~lastQ;
endmodule

// *** dv/cdmf_core_tb.sv ***
// self-checking bench for the data-move and flag core
`timescale 1ns/1ns
module cdmf_core_tb
  import cdmf_pkg::*;
();
  logic           clk = 1'b0;
  logic           rst_n = 1'b0;
  logic [7:0]     memRdata;
  cdmf_flag_req_t flagReq = '0;
  cdmf_mem_t      mem;
  cdmf_flags_t    flags;
  logic [15:0]    pc;
  logic [7:0]     acc;
  logic           instrDone;
  int             miscompares = 0;
  int             check_count = 0;
  logic [7:0] prog [0:27] = '{8'h3E, 8'h5A, 8'h32, 8'h00, 8'h20, 8'h21, 8'h34, 8'h12, 8'h22, 8'h10, 8'h20, 8'h7C,
    8'h3A, 8'h10, 8'h20, 8'h77, 8'h36, 8'h99, 8'h7E, 8'h11, 8'h00, 8'h20, 8'h1A, 8'h2A, 8'hFF, 8'hFF, 8'h7D, 8'hE9};
  logic [7:0] expAcc [0:17] = '{8'h5A, 8'h5A, 8'h5A, 8'h5A, 8'h12, 8'h34, 8'h34, 8'h34, 8'h99, 8'h99, 8'h5A, 8'h5A,
    8'h21, 8'h21, 8'h21, 8'h77, 8'h77, 8'h33};
  int expSt [0:17] = '{7, 13, 10, 16, 4, 13, 7, 10, 7, 10, 7, 16, 4, 4, 4, 7, 10, 7};
  // address of the next instruction once each one has finished
  logic [15:0] expPc [0:17] = '{16'h0002, 16'h0005, 16'h0008, 16'h000B, 16'h000C, 16'h000F, 16'h0010, 16'h0012,
    16'h0013, 16'h0016, 16'h0017, 16'h001A, 16'h001B, 16'h3E21, 16'h0028, 16'h002A, 16'h3000, 16'h3002};
  always #20 clk = ~clk;
  cdmf_core cdmf_core_inst (.clk(clk), .rst_n(rst_n), .memRdata(memRdata), .flagReq(flagReq), .mem(mem),
    .flags(flags), .pc(pc), .acc(acc), .instrDone(instrDone));
  cdmf_mem_model cdmf_mem_model_inst (.clk(clk), .memBus(mem), .memRdata(memRdata));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // program walks every transfer kind, then jumps by pair, restart and direct target
  task automatic runProgram();
    int last, cyc, k;
    last = 0;
    cyc = 0;
    k = 0;
    while (k < 18 && cyc < 2000) begin
      @(posedge clk);
      #1;
      cyc++;
      if (instrDone === 1'b1) begin
        check("acc", acc, expAcc[k]);
        check("flags", flags, 16'h000E);
        check("pc", pc, expPc[k]);
        if (k > 0) check("states", 16'(cyc - last), 16'(expSt[k]));
        last = cyc;
        k++;
      end
    end
    // a hang counts once and still reaches the closing report
    if (k < 18) miscompares++;
  endtask
  task automatic checkMemory();
    check("direct store", cdmf_mem_model_inst.memQ[16'h2000], 16'h005A);
    check("pair low", cdmf_mem_model_inst.memQ[16'h2010], 16'h0034);
    check("pair high", cdmf_mem_model_inst.memQ[16'h2011], 16'h0012);
    check("indirect byte", cdmf_mem_model_inst.memQ[16'h1234], 16'h0099);
  endtask
  task automatic applyFlags(input logic s, input logic cw, input logic [7:0] a, input logic [7:0] b,
                            input logic c, input logic [4:0] e);
    @(posedge clk);
    flagReq <= '{we: 1'b1, carryWe: cw, sub: s, opA: a, opB: b, cin: c};
    @(posedge clk);
    flagReq.we <= 1'b0;
    #1;
    check("flags", flags, 16'(e));
  endtask
  initial begin
    #1;
    for (int i = 0; i < 28; i++) cdmf_mem_model_inst.memQ[i] = prog[i];
    // wrapped second byte of the pair load lands on address zero
    cdmf_mem_model_inst.memQ[16'hFFFF] = 8'h21;
    cdmf_mem_model_inst.memQ[16'h3E21] = 8'hEF;
    cdmf_mem_model_inst.memQ[16'h0028] = 8'h3E;
    cdmf_mem_model_inst.memQ[16'h0029] = 8'h77;
    cdmf_mem_model_inst.memQ[16'h002A] = 8'hC3;
    cdmf_mem_model_inst.memQ[16'h002B] = 8'h00;
    cdmf_mem_model_inst.memQ[16'h002C] = 8'h30;
    cdmf_mem_model_inst.memQ[16'h3000] = 8'h3E;
    cdmf_mem_model_inst.memQ[16'h3001] = 8'h33;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // flags set while the first transfer runs must survive the whole program
    applyFlags(1'b1, 1'b1, 8'h05, 8'h05, 1'b0, 5'h0E);
    // pair load across the top of the space
    runProgram();
    checkMemory();
    applyFlags(1'b0, 1'b1, 8'h0F, 8'h01, 1'b0, 5'h04);
    applyFlags(1'b0, 1'b1, 8'hFF, 8'h01, 1'b0, 5'h0F);
    applyFlags(1'b0, 1'b0, 8'h01, 8'h01, 1'b0, 5'h01);
    applyFlags(1'b1, 1'b1, 8'h00, 8'h01, 1'b0, 5'h13);
    applyFlags(1'b1, 1'b1, 8'h05, 8'h05, 1'b0, 5'h0E);
    conclude();
  end
endmodule
